//--- sim/sbp_motor_model.sv
// Behavioural motor with holding brake and host speed demand
`timescale 1ns/100ps
module sbp_motor_model
    import sbp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Drive outputs of the sequencer
    input wire logic i_energize,
    input wire logic i_brake_rel,
    // Host demand and coast friction
    input wire logic [15:0] i_target,
    input wire logic [15:0] i_decel,
    // Shaft speed back to the drive
    output logic [15:0] o_speed
);
    logic [15:0] spd_q; // Shaft speed
    logic [15:0] spd_d; // Next shaft speed
    ////////////////////////////////////////
    // Speed law: brake holds, drive ramps, else coasts
    always_comb
    begin
        if (!i_brake_rel)
        begin
            // Engaged brake locks the shaft at once
            spd_d = 16'h0000;
        end
        else if (i_energize)
        begin
            // Host ramps only while the brake is open
            spd_d = (spd_q < i_target) ? spd_q + 16'h0001 :
                    (spd_q > i_target) ? spd_q - 16'h0001 : spd_q;
        end
        else
        begin
            // Unpowered shaft loses speed to friction
            spd_d = (spd_q > i_decel) ? spd_q - i_decel : 16'h0000;
        end
    end
    // Speed register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            spd_q <= 16'h0000;
        else
            spd_q <= spd_d;
    end
    assign o_speed = spd_q;
endmodule : sbp_motor_model

//--- sim/tb_servo_brake_protection_sequencer.sv
// Self-checking bench for the brake and protection sequencer
`timescale 1ns/100ps
module tb_servo_brake_protection_sequencer
    import sbp_pkg::*;
;
    localparam int TICK = 8; // Short millisecond for simulation
    logic clk, rst, cyc, stb, we, ack, son, al1, al2; // Bus and pins
    logic brk, en, warn, cont, inst, buv; // Flags seen
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [15:0] spd, cur, rated, batt, tgt, dec, tlim, regw;
    logic [2:0] stop;
    int n_fail, compares;
    ////////////////////////////////////////
    always #2 clk = ~clk;
    sbp_brake_seq #(.TICK_CYCLES(TICK), .OL_LIMIT(32'h0000_0100)) sbp_brake_seq_inst (
        .I_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_SERVO_ON(son), .I_ALARM_T1(al1), .I_ALARM_T2(al2), .I_MOTOR_SPEED(spd),
        .I_MOTOR_CURRENT(cur), .I_RATED_CURRENT(rated), .I_BATT_MV(batt),
        .O_BRAKE_RELEASE(brk), .O_MOTOR_ENERGIZE(en), .O_STOP_METHOD(stop),
        .O_TORQUE_LIMIT(tlim), .O_OL_WARN(warn), .O_OL_CONT_ALARM(cont),
        .O_OL_INST_ALARM(inst), .O_BATT_UV_ALARM(buv), .O_REGEN_WATTS(regw));
    sbp_motor_model sbp_motor_model_inst (.i_clk(clk), .i_rst(rst), .i_energize(en),
        .i_brake_rel(brk), .i_target(tgt), .i_decel(dec), .o_speed(spd));
    ////////////////////////////////////////
    // Verdict and end of run
    task automatic end_sim;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Value and flag comparisons
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val
    task automatic chk_flag(input string nm, input logic e, input logic g);
        chk_val(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_flag
    // Single classic cycle; no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= {16'h0000, d};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1)
        begin
            n_fail++;
            $display("unexpected ack expected 1 seen %b", ack);
            end_sim();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] x;
        wb(1'b0, a, 16'h0000, x);
        chk_val("register", {16'h0000, e}, x);
    endtask : rdchk
    // Bounded wait for a flag; called just after an edge
    function automatic logic pick(input int s);
        case (s)
            0: pick = brk;
            1: pick = en;
            2: pick = warn;
            3: pick = cont;
            4: pick = inst;
            5: pick = buv;
            default: pick = (spd >= tgt);
        endcase
    endfunction : pick
    task automatic wait_sig(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (pick(s) !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (pick(s) !== v)
        begin
            n_fail++;
            $display("unexpected flag %0d expected %b seen %b", s, v, pick(s));
            end_sim();
        end
    endtask : wait_sig
    // Ten-cycle reset with quiet pins
    task automatic rst_dut;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        {son, al1, al2} <= 3'h0;
        {tgt, dec, cur, rated, batt} <= {16'h0000, 16'h0002, 16'h0000, 16'h0064, 16'h0e10};
        @(posedge clk);
    endtask : rst_dut
    // Servo on, wait for open brake, then command speed
    task automatic spin(input logic [15:0] t);
        int n;
        son <= 1'b1;
        wait_sig(0, 1'b1, 20, n);
        tgt <= t;
        @(posedge clk);
        wait_sig(6, 1'b1, 700, n);
    endtask : spin
    ////////////////////////////////////////
    task automatic sc_regs;
        rst_dut();
        chk_val("tlim", 32'h0000_ffff, {16'h0000, tlim});
        rdchk(OFS_SPD_THR, RST_SPD_THR);
        rdchk(OFS_WAIT, RST_WAIT);
        rdchk(OFS_WARN_RATIO, 16'h0014);
        rdchk(OFS_DERATE, RST_DERATE);
        rdchk(OFS_ENC_SEL, 16'h0000);
        rdchk(8'h80, 16'h0000);
        rdchk(OFS_STATUS, 16'h0000);
        wr(OFS_ENC_SEL, 16'h0001);
        rdchk(OFS_ENC_SEL, 16'h0001);
        wr(OFS_REGEN, 16'h0002);
        wr(OFS_REGEN_W, 16'h0055);
        rdchk(OFS_REGEN_W, 16'h0014);
        chk_val("watts", 32'h0000_0014, {16'h0000, regw});
    endtask : sc_regs
    // Stopped motor: brake with servo-on, power after lock time
    task automatic sc_still;
        int n, m;
        rst_dut();
        wr(OFS_CTRL, 16'h0003);
        wr(OFS_LOCK, 16'h0003);
        spin(16'h0000);
        son <= 1'b0;
        wait_sig(0, 1'b0, 6, n);
        chk_flag("energized", 1'b1, en);
        chk_flag("brake_delay", 1'b1, n <= 4);
        chk_val("stop", 32'h3, {29'h0, stop});
        wait_sig(1, 1'b0, 40, m);
        chk_flag("lock_time", 1'b1, m >= 2 * TICK && m <= 3 * TICK + 2);
    endtask : sc_still
    // Alarm while rotating; speed threshold wins, or wait time wins
    task automatic sc_rot(input logic [15:0] wt, input logic [15:0] dc);
        int n;
        rst_dut();
        wr(OFS_WAIT, wt);
        dec <= dc;
        spin(16'd500);
        al1 <= 1'b1;
        wait_sig(1, 1'b0, 6, n);
        chk_flag("brake_held", 1'b1, brk);
        wait_sig(0, 1'b0, 400, n);
        if (dc != 0)
            chk_flag("spd_cross", 1'b1, spd < 16'd100 && spd > 16'd90);
        else
            chk_flag("wait_time", 1'b1, n >= TICK && n <= 2 * TICK + 2);
    endtask : sc_rot
    // Type 2 alarm with zero speed stop selected
    task automatic sc_zero;
        rst_dut();
        wr(OFS_CTRL, 16'h0005);
        wr(OFS_ZLIM, 16'h0030);
        spin(16'd500);
        al2 <= 1'b1;
        repeat (4) @(posedge clk);
        chk_val("stop", 32'h4, {29'h0, stop});
        chk_val("tlim", 32'h0030, {16'h0000, tlim});
        chk_flag("energized", 1'b1, en);
    endtask : sc_zero
    // Battery threshold, and no check in incremental use
    task automatic sc_batt;
        int n;
        rst_dut();
        batt <= 16'd3200;
        repeat (6) @(posedge clk);
        chk_flag("buv_3200", 1'b0, buv);
        batt <= 16'd3199;
        wait_sig(5, 1'b1, 10, n);
        chk_flag("buv_3199", 1'b1, buv);
        rst_dut();
        wr(OFS_ENC_SEL, 16'h0001);
        batt <= 16'd3199;
        repeat (6) @(posedge clk);
        chk_flag("buv_incr", 1'b0, buv);
    endtask : sc_batt
    // Fixed instantaneous level; derated continuous base
    task automatic sc_ol;
        int n;
        rst_dut();
        cur <= 16'd299;
        repeat (8) @(posedge clk);
        chk_flag("inst_299", 1'b0, inst);
        cur <= 16'd300;
        wait_sig(4, 1'b1, 10, n);
        chk_flag("inst_300", 1'b1, inst);
        rst_dut();
        cur <= 16'd110;
        repeat (64) @(posedge clk);
        chk_flag("cont_110", 1'b0, cont | warn);
        wr(OFS_DERATE, 16'd50);
        wait_sig(2, 1'b1, 40, n);
        chk_flag("cont_at_warn", 1'b0, cont);
        wait_sig(3, 1'b1, 40, n);
        chk_flag("cont_derated", 1'b1, cont);
    endtask : sc_ol
    ////////////////////////////////////////
    initial
    begin
        {clk, rst, cyc, stb, we, son, al1, al2} = 8'h40;
        {adr, sel, wdat} = 44'h0;
        {tgt, dec, cur, rated, batt} = {16'h0000, 16'h0002, 16'h0000, 16'h0064, 16'h0e10};
        n_fail = 0;
        compares = 0;
        sc_regs();
        sc_still();
        sc_rot(16'h0064, 16'h0002);
        sc_rot(16'h0002, 16'h0000);
        sc_zero();
        sc_batt();
        sc_ol();
        end_sim();
    end
endmodule : tb_servo_brake_protection_sequencer

//--- verilog/sbp_brake_seq.sv
// Brake and protection sequencer with Wishbone register file
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
module sbp_brake_seq
    import sbp_pkg::*;
#(
    parameter int TICK_CYCLES = CYC_PER_MS,
    parameter logic [31:0] OL_LIMIT = 32'h0010_0000
)(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Pins from the host
    input wire logic I_SERVO_ON,
    input wire logic I_ALARM_T1,
    input wire logic I_ALARM_T2,
    // Measurements from same-clock logic
    input wire logic [15:0] I_MOTOR_SPEED,
    input wire logic [15:0] I_MOTOR_CURRENT,
    input wire logic [15:0] I_RATED_CURRENT,
    input wire logic [15:0] I_BATT_MV,
    // Drive and brake controls
    output logic O_BRAKE_RELEASE,
    output logic O_MOTOR_ENERGIZE,
    output logic [2:0] O_STOP_METHOD,
    output logic [15:0] O_TORQUE_LIMIT,
    // Protection flags and regen capacity in watts
    output logic O_OL_WARN,
    output logic O_OL_CONT_ALARM,
    output logic O_OL_INST_ALARM,
    output logic O_BATT_UV_ALARM,
    output logic [15:0] O_REGEN_WATTS
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and overload detector
    logic [2:0] pins_s; // Servo-on, type 1, type 2
    logic son, t1, t2;
    logic ol_warn, ol_cont, ol_inst;

    sbp_sync2 #(.WIDTH(3)) sbp_sync2_inst (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_async({I_SERVO_ON, I_ALARM_T1, I_ALARM_T2}),
        .o_sync(pins_s)
    );
    assign son = pins_s[2];
    assign t1 = pins_s[1];
    assign t2 = pins_s[0];

    logic [15:0] ratio_q, derate_q; // Overload settings

    sbp_overload #(.OL_LIMIT(OL_LIMIT)) sbp_overload_inst (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_current(I_MOTOR_CURRENT),
        .i_rated(I_RATED_CURRENT),
        .i_warn_ratio(ratio_q),
        .i_derate(derate_q),
        .o_warn(ol_warn),
        .o_cont(ol_cont),
        .o_inst(ol_inst)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register file over Wishbone
    logic [15:0] ctrl_q, ctrl_d; // Stop method and zero stop enable
    logic [15:0] thr_q, thr_d; // Brake speed threshold
    logic [15:0] wait_q, wait_d; // Brake wait time, ms
    logic [15:0] lock_q, lock_d; // Motor lock time, ms
    logic [15:0] regen_q, regen_d; // Regen capacity, counts
    logic [15:0] ratio_d, derate_d; // Overload ratio and derate, percent
    logic [15:0] zlim_q, zlim_d; // Zero-stop torque limit
    logic [15:0] enc_q, enc_d; // Encoder usage select
    logic [31:0] rdat_q, rdat_d; // Read data register
    logic ack_q, ack_d;
    logic wr; // Write taken this cycle
    logic [31:0] status; // Live status word
    sbp_state_e state_q, state_d;
    logic brake_q, energize_q, batt_q;

    // Decode, write merge and read mux
    always_comb
    begin
        ack_d = I_WB_CYC & I_WB_STB & ~ack_q;
        // Write commits at the edge where the master samples ack high
        wr = I_WB_CYC & I_WB_STB & I_WB_WE & ack_q;
        ctrl_d = ctrl_q;
        thr_d = thr_q;
        wait_d = wait_q;
        lock_d = lock_q;
        regen_d = regen_q;
        ratio_d = ratio_q;
        derate_d = derate_q;
        zlim_d = zlim_q;
        enc_d = enc_q;
        status = {24'h0, ol_inst, ol_cont, ol_warn, batt_q, energize_q, brake_q, state_q};
        rdat_d = 32'h0; // Unmapped and reserved read zero
        case (I_WB_ADR)
            OFS_CTRL: rdat_d = {16'h0, ctrl_q};
            OFS_SPD_THR: rdat_d = {16'h0, thr_q};
            OFS_WAIT: rdat_d = {16'h0, wait_q};
            OFS_LOCK: rdat_d = {16'h0, lock_q};
            OFS_REGEN: rdat_d = {16'h0, regen_q};
            OFS_WARN_RATIO: rdat_d = {16'h0, ratio_q};
            OFS_DERATE: rdat_d = {16'h0, derate_q};
            OFS_ZLIM: rdat_d = {16'h0, zlim_q};
            OFS_STATUS: rdat_d = status;
            OFS_REGEN_W: rdat_d = {16'h0, O_REGEN_WATTS};
            OFS_ENC_SEL: rdat_d = {16'h0, enc_q};
            default: rdat_d = 32'h0;
        endcase
        if (wr)
        begin
            case (I_WB_ADR)
                OFS_CTRL: ctrl_d = sbp_merge(ctrl_q, I_WB_DAT, I_WB_SEL);
                OFS_SPD_THR: thr_d = sbp_merge(thr_q, I_WB_DAT, I_WB_SEL);
                OFS_WAIT: wait_d = sbp_merge(wait_q, I_WB_DAT, I_WB_SEL);
                OFS_LOCK: lock_d = sbp_merge(lock_q, I_WB_DAT, I_WB_SEL);
                OFS_REGEN: regen_d = sbp_merge(regen_q, I_WB_DAT, I_WB_SEL);
                OFS_WARN_RATIO: ratio_d = sbp_merge(ratio_q, I_WB_DAT, I_WB_SEL);
                OFS_DERATE: derate_d = sbp_merge(derate_q, I_WB_DAT, I_WB_SEL);
                OFS_ZLIM: zlim_d = sbp_merge(zlim_q, I_WB_DAT, I_WB_SEL);
                OFS_ENC_SEL: enc_d = sbp_merge(enc_q, I_WB_DAT, I_WB_SEL);
                default: ; // Unmapped writes acked, dropped
            endcase
        end
    end

    // Register bank
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            ctrl_q <= RST_CTRL;
            thr_q <= RST_SPD_THR;
            wait_q <= RST_WAIT;
            lock_q <= RST_LOCK;
            regen_q <= RST_REGEN;
            ratio_q <= RST_WARN_RATIO;
            derate_q <= RST_DERATE;
            zlim_q <= RST_ZLIM;
            enc_q <= RST_ENC_SEL;
            rdat_q <= 32'h0;
            ack_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            thr_q <= thr_d;
            wait_q <= wait_d;
            lock_q <= lock_d;
            regen_q <= regen_d;
            ratio_q <= ratio_d;
            derate_q <= derate_d;
            zlim_q <= zlim_d;
            enc_q <= enc_d;
            rdat_q <= rdat_d;
            ack_q <= ack_d;
        end
    end

    assign O_WB_DAT = rdat_q;
    assign O_WB_ACK = ack_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Brake sequencer
    logic [31:0] pre_q, pre_d; // Millisecond prescaler
    logic tick; // One cycle per ms
    logic [15:0] tmr_q, tmr_d; // Ms spent in current state
    logic alarm, zstop, stopped, stop_req;
    logic brake_d, energize_d, batt_d;
    logic [2:0] method_q, method_d;
    logic [15:0] tlim_q, tlim_d, watts_q, watts_d;

    // Next state, timer and outputs
    always_comb
    begin
        tick = (pre_q == 32'(TICK_CYCLES - 1));
        pre_d = tick ? 32'h0 : pre_q + 32'h1;
        // Only multi-turn use watches the battery
        batt_d = (enc_q[0] == 1'b0) && (I_BATT_MV < BATT_MIN_MV);
        alarm = t1 | t2 | ol_cont | ol_inst | batt_q;
        // Type 2 alone may pick zero speed stop
        zstop = t2 & ctrl_q[CTRL_ZSP_BIT] & ~(t1 | ol_cont | ol_inst | batt_q);
        stopped = I_MOTOR_SPEED < STOP_SPEED;
        stop_req = alarm | ~son;
        state_d = state_q;
        case (state_q)
            S_OFF:
                if (son && !alarm)
                    state_d = S_ON;
            S_ON:
                if (stop_req)
                    state_d = stopped ? S_LOCK : S_COAST;
            S_LOCK:
                if (tmr_q >= lock_q)
                    state_d = S_OFF;
            S_COAST:
                // First of speed or wait ends the release
                if ((I_MOTOR_SPEED < thr_q) || (tmr_q >= wait_q))
                    state_d = S_OFF;
            default:
                state_d = S_OFF;
        endcase
        // Timer restarts on every state change, saturates
        if (state_d != state_q)
            tmr_d = 16'h0;
        else if (tick && tmr_q != 16'hffff)
            tmr_d = tmr_q + 16'h1;
        else
            tmr_d = tmr_q;
        brake_d = (state_d == S_ON) || (state_d == S_COAST);
        energize_d = (state_d == S_ON) || (state_d == S_LOCK) ||
                     ((state_d == S_COAST) && zstop);
        if (state_d == S_OFF || state_d == S_ON)
            method_d = STOP_NONE;
        else if (zstop)
            method_d = STOP_ZERO;
        else
            method_d = {1'b0, ctrl_q[CTRL_T1_LSB +: 2]};
        tlim_d = zstop ? zlim_q : 16'hffff;
        watts_d = 16'(regen_q * REGEN_W_PER_CNT);
    end

    // Sequencer registers; all but the bus and overload outputs come from these flops
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            pre_q <= 32'h0;
            tmr_q <= 16'h0;
            state_q <= S_OFF;
            brake_q <= 1'b0;
            energize_q <= 1'b0;
            batt_q <= 1'b0;
            method_q <= STOP_NONE;
            tlim_q <= 16'hffff;
            watts_q <= 16'h0;
        end
        else
        begin
            pre_q <= pre_d;
            tmr_q <= tmr_d;
            state_q <= state_d;
            brake_q <= brake_d;
            energize_q <= energize_d;
            batt_q <= batt_d;
            method_q <= method_d;
            tlim_q <= tlim_d;
            watts_q <= watts_d;
        end
    end

    // Brake release stays low until running: host waits on it
    assign O_BRAKE_RELEASE = brake_q;
    assign O_MOTOR_ENERGIZE = energize_q;
    assign O_STOP_METHOD = method_q;
    assign O_TORQUE_LIMIT = tlim_q;
    assign O_OL_WARN = ol_warn;
    assign O_OL_CONT_ALARM = ol_cont;
    assign O_OL_INST_ALARM = ol_inst;
    assign O_BATT_UV_ALARM = batt_q;
    assign O_REGEN_WATTS = watts_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence run_stop_s;
        state_q == S_ON && stop_req;
    endsequence

    zero_stop_sel_a: assert property (run_stop_s and (zstop && !stopped)
        |=> O_STOP_METHOD == STOP_ZERO) else $error("zero speed stop not chosen");
    alarm_stop_a: assert property (run_stop_s and (alarm && !zstop && !stopped)
        |=> !O_MOTOR_ENERGIZE ##0 state_q == S_COAST) else $error("alarm did not stop motor");
    speed_drop_a: assert property ((state_q == S_COAST && I_MOTOR_SPEED < thr_q)
        |=> !O_BRAKE_RELEASE) else $error("brake held below speed threshold");
    wait_drop_a: assert property ((state_q == S_COAST && tmr_q >= wait_q)
        |=> !O_BRAKE_RELEASE ##0 state_q == S_OFF) else $error("brake held past wait time");
    coast_hold_a: assert property ((state_q == S_COAST && I_MOTOR_SPEED >= thr_q &&
        tmr_q < wait_q) |=> O_BRAKE_RELEASE) else $error("brake dropped early");
    stop_brake_a: assert property (run_stop_s and stopped
        |=> !O_BRAKE_RELEASE && O_MOTOR_ENERGIZE) else $error("stopped brake timing wrong");
    lock_hold_a: assert property ((state_q == S_LOCK && tmr_q < lock_q)
        |=> O_MOTOR_ENERGIZE) else $error("lock time cut short");
    regen_scale_a: assert property (##1 O_REGEN_WATTS == 16'($past(regen_q) * 16'h000a))
        else $error("regen scaling wrong");
    batt_low_a: assert property ((enc_q[0] == 1'b0 && I_BATT_MV < 16'h0c80)
        |=> O_BATT_UV_ALARM) else $error("battery low not flagged");
    batt_incr_a: assert property (enc_q[0] |=> !O_BATT_UV_ALARM)
        else $error("battery alarm in incremental use");
endmodule : sbp_brake_seq

//--- verilog/sbp_overload.sv
// Overload detector: warning, continuous and instantaneous alarms
`timescale 1ns/100ps
module sbp_overload
    import sbp_pkg::*;
#(
    parameter logic [31:0] OL_LIMIT = 32'h0010_0000
)(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Currents and settings
    input wire logic [15:0] i_current,
    input wire logic [15:0] i_rated,
    input wire logic [15:0] i_warn_ratio,
    input wire logic [15:0] i_derate,
    // Detections
    output logic o_warn,
    output logic o_cont,
    output logic o_inst
);
    logic [31:0] base; // Derated base current
    logic [31:0] cur; // Widened current
    logic [31:0] acc_q, acc_d; // Heat accumulator
    logic warn_d, cont_d, inst_d;
    logic warn_q, cont_q, inst_q;

    // Accumulate excess, decay below base
    always_comb
    begin
        cur = {16'h0000, i_current};
        base = sbp_pct(sbp_pct({16'h0000, i_rated}, OL_BASE_PCT), {16'h0000, i_derate});
        acc_d = acc_q;
        if (cur > base)
            acc_d = (acc_q > OL_LIMIT) ? acc_q : acc_q + (cur - base);
        else
            acc_d = (acc_q > (base - cur)) ? acc_q - (base - cur) : 32'h0;
        // Warning point tracks the ratio, same heat model
        warn_d = acc_d >= sbp_pct(OL_LIMIT, {16'h0000, i_warn_ratio});
        cont_d = acc_d >= OL_LIMIT;
        // Fixed level, no setting reaches it
        inst_d = cur >= sbp_pct({16'h0000, i_rated}, OL_INST_PCT);
    end

    // Register accumulator and flags
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            acc_q <= 32'h0;
            warn_q <= 1'b0;
            cont_q <= 1'b0;
            inst_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            warn_q <= warn_d;
            cont_q <= cont_d;
            inst_q <= inst_d;
        end
    end

    assign o_warn = warn_q;
    assign o_cont = cont_q;
    assign o_inst = inst_q;

    // Instantaneous trip follows current at fixed level
    inst_fixed_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ({16'h0000, i_current} >= sbp_pct({16'h0000, i_rated}, OL_INST_PCT)) |=> o_inst)
        else $error("instantaneous overload not flagged");
endmodule : sbp_overload

//--- verilog/sbp_pkg.sv
// Package of constants, types and helpers for the brake and protection sequencer
// Summary of operation
// - Type 2 alarms may select zero speed stop
// - Alarm while rotating stops motor, drops brake
// - Brake drops when speed below brake threshold
// - Brake drops when brake wait time elapses
// - Stopped: brake drops with servo-on falling
// - Stopped: energy held for motor lock time
// - Regen capacity counts in ten watt steps
// - Warning time is ratio of alarm time
// - Instantaneous overload level fixed, not programmable
// - Continuous base current 1.15 times rated, derated
// - Battery below 3.2 V raises alarm in multi-turn use only
// - Encoder select 0 multi-turn, 1 incremental
package sbp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SPD_THR = 8'h04;
    localparam logic [7:0] OFS_WAIT = 8'h08;
    localparam logic [7:0] OFS_LOCK = 8'h0c;
    localparam logic [7:0] OFS_REGEN = 8'h10;
    localparam logic [7:0] OFS_WARN_RATIO = 8'h14;
    localparam logic [7:0] OFS_DERATE = 8'h18;
    localparam logic [7:0] OFS_ZLIM = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_REGEN_W = 8'h24;
    localparam logic [7:0] OFS_ENC_SEL = 8'h40;
    // Control fields
    localparam int CTRL_T1_LSB = 0;
    localparam int CTRL_ZSP_BIT = 2;
    // Reset values
    localparam logic [15:0] RST_CTRL = 16'h0001;
    localparam logic [15:0] RST_SPD_THR = 16'h0064;
    localparam logic [15:0] RST_WAIT = 16'h0064;
    localparam logic [15:0] RST_LOCK = 16'h0000;
    localparam logic [15:0] RST_REGEN = 16'h0000;
    localparam logic [15:0] RST_WARN_RATIO = 16'h0014;
    localparam logic [15:0] RST_DERATE = 16'h0064;
    localparam logic [15:0] RST_ZLIM = 16'h0064;
    localparam logic [15:0] RST_ENC_SEL = 16'h0000;
    // Scaling figures
    localparam logic [15:0] REGEN_W_PER_CNT = 16'h000a;
    localparam logic [31:0] OL_BASE_PCT = 32'h0000_0073;
    localparam logic [31:0] OL_INST_PCT = 32'h0000_012c;
    localparam logic [15:0] BATT_MIN_MV = 16'h0c80;
    localparam logic [15:0] STOP_SPEED = 16'h000a;
    // Timing: one millisecond tick
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 1000000;
    localparam int CYC_PER_MS = TICK_NS / CLK_PERIOD_NS;
    // Stop method encodings
    localparam logic [2:0] STOP_NONE = 3'h0;
    localparam logic [2:0] STOP_ZERO = 3'h4;
    // Sequencer states, Gray only in OFF, ON, COAST, LOCK order; ON to LOCK and COAST to OFF flip both bits
    typedef enum logic [1:0] {
        S_OFF = 2'b00,
        S_ON = 2'b01,
        S_COAST = 2'b11,
        S_LOCK = 2'b10
    } sbp_state_e;

    // Percent scaling, value times percent over hundred
    function automatic logic [31:0] sbp_pct(input logic [31:0] val, input logic [31:0] pct);
        sbp_pct = (val * pct) / 32'd100;
    endfunction : sbp_pct

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] sbp_merge(input logic [15:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
        sbp_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction : sbp_merge
endpackage : sbp_pkg

//--- verilog/sbp_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sbp_sync2
    import sbp_pkg::*;
#(
    parameter int WIDTH = 1
)(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Asynchronous levels in, synchronised out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q; // First stage, read only by second
    logic [WIDTH-1:0] sync_q; // Second stage

    // Both stages clear on reset
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : sbp_sync2
